// ### src/idr_pkg.sv
// Constants for the island data image register bank.
// Assumes one clock domain; register indices count from the first image register.
package idr_pkg;

  localparam int DATA_W   = 16;
  localparam int IDX_W    = 14;
  localparam int REF_BASE = 40001;
  localparam int IMG_SIZE = 9999;

  // Block start indices and sizes, fixed whatever the application uses.
  localparam logic [13:0] OUT_BASE  = 14'h0000;
  localparam int          OUT_SIZE  = 4096;
  localparam logic [13:0] F2P_BASE  = 14'h1000;
  localparam int          F2P_SIZE  = 512;
  localparam logic [13:0] RSV_BASE  = 14'h1200;
  localparam logic [13:0] RSV9_BASE = 14'h1400;
  localparam logic [13:0] REQ_BASE  = 14'h1409;
  localparam int          REQ_SIZE  = 5;
  localparam logic [13:0] R114_BASE = 14'h140e;
  localparam logic [13:0] R54_BASE  = 14'h1480;
  localparam logic [13:0] RESP_BASE = 14'h14b6;
  localparam int          RESP_SIZE = 4;
  localparam logic [13:0] RO_BASE   = 14'h14ba;
  localparam logic [13:0] STAT_BASE = 14'h14ec;
  localparam int          STAT_SIZE = 35;
  localparam logic [13:0] INP_BASE  = 14'h150f;
  localparam int          INP_SIZE  = 4096;
  localparam logic [13:0] P2F_BASE  = 14'h250f;
  localparam int          P2F_SIZE  = 512;
  localparam logic [13:0] IMG_END   = 14'h270f;

  // Panel-writable part of the panel-to-fieldbus table.
  localparam logic [13:0] P2F_WR_COUNT = 14'h0200;

  // Protection control registers above the image.
  localparam logic [13:0] CTRL_IDX   = 14'h2710;
  localparam logic [13:0] KEY0_IDX   = 14'h2711;
  localparam logic [13:0] KEYLEN_IDX = 14'h2714;
  localparam logic [13:0] CMD_IDX    = 14'h2715;
  localparam logic [13:0] STATUS_IDX = 14'h2716;

  localparam int CTRL_TEST_BIT = 0;
  localparam int CTRL_PROT_BIT = 1;

  localparam int STS_PROT_BIT    = 0;
  localparam int STS_OPEN_BIT    = 1;
  localparam int STS_REFUSED_BIT = 2;

  localparam logic [15:0] CMD_UNLOCK = 16'h0001;
  localparam logic [15:0] CMD_LOCK   = 16'h0002;
  localparam logic [15:0] CMD_SET_PW = 16'h0003;
  localparam logic [15:0] CMD_SAVE   = 16'h0004;
  localparam logic [15:0] CMD_CARD   = 16'h0005;

  localparam int          PW_CHARS = 6;
  localparam logic [3:0]  PW_MAXLEN = 4'h6;
  localparam logic [15:0] RST_WORD  = 16'h0000;

  typedef enum logic [3:0] {
    BLK_OUT, BLK_F2P, BLK_RSV, BLK_REQ, BLK_RESP, BLK_RO,
    BLK_STAT, BLK_INP, BLK_P2F, BLK_CTRL, BLK_NONE
  } idr_blk_t;

endpackage

// ### src/idr_regs.sv
// Island data image register bank with configuration write protection.
// Assumes all ports are synchronous to clk and strobes are one cycle long.
// How it works
// (RL1) 9999 registers numbered from 40001.
// (RL2) Every register is sixteen bits wide.
// (RL3) Output image: first 4096 registers.
// (RL4) Then fieldbus-to-panel table, then reserved block.
// (RL5) Reserved blocks sit at fixed positions.
// (RL6) Five-word request and four-word response blocks.
// (RL7) Thirty-five status registers precede input image.
// (RL8) Input image spans 45392 to 49487.
// (RL9) Panel writes configured panel-to-fieldbus registers; the code lets it write all 512 words of the table.
// (RL10) Block sizes and positions never change.
// (RL11) Panel can read every image register.
// (RL12) Panel writes output image only in test mode.
// (RL13) Output image holds latest fieldbus output data.
// (RL14) Digital channel one bit 0, two bit 1.
// (RL15) Output registers follow island bus address order.
// (RL16) Analog channels get own register, left-justified.
// (RL17) Protection blocks config overwrite, reads stay open.
// (RL18) Protection disables the configuration reset button.
// (RL19) Protection ignores an inserted removable card.
// (RL20) Passwords: up to six alphanumerics, case-sensitive.
// (RL21) Save stores password together with configuration.
// (RL22) Save commits config; card store overwrites card.
// (RL23) Writes to unwritable registers are ignored.
//
// Implementation choices: the placing of the registers and the address-and-strobe port.
module idr_regs (
  input  wire logic        clk,
  input  wire logic        rst,
  // Configuration port (operator panel)
  input  wire logic [13:0] addr,
  input  wire logic [15:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic      [15:0] rdata,
  // Fieldbus master port
  input  wire logic [13:0] fb_addr,
  input  wire logic [15:0] fb_wdata,
  input  wire logic        fb_wr,
  input  wire logic        fb_rd,
  output logic      [15:0] fb_rdata,
  // Island side port
  input  wire logic [13:0] isl_addr,
  input  wire logic [15:0] isl_wdata,
  input  wire logic        isl_wr,
  input  wire logic        isl_rd,
  output logic      [15:0] isl_rdata,
  // Operator controls
  input  wire logic        reset_button,
  input  wire logic        card_present,
  // Configuration actions
  output logic             cfg_save,
  output logic             card_store,
  output logic             card_load,
  output logic             cfg_reset,
  output logic             test_mode,
  output logic      [47:0] saved_pw,
  output logic      [3:0]  saved_pw_len,
  output logic             saved_pw_en
);

  // Data storage; left without reset because it is data, not control state.
  logic [15:0] out_img [idr_pkg::OUT_SIZE];                          // [RL2]
  logic [15:0] f2p_tab [idr_pkg::F2P_SIZE];
  logic [15:0] req_blk [idr_pkg::REQ_SIZE];
  logic [15:0] resp_blk [idr_pkg::RESP_SIZE];
  logic [15:0] stat_blk [idr_pkg::STAT_SIZE];
  logic [15:0] inp_img [idr_pkg::INP_SIZE];
  logic [15:0] p2f_tab [idr_pkg::P2F_SIZE];

  logic        prot_en_reg;
  logic        unlocked_reg;
  logic        refused_reg;
  logic [47:0] pw_reg;
  logic [3:0]  pw_len_reg;
  logic [15:0] key_reg [3];
  logic [3:0]  key_len_reg;
  logic        button_prev_reg;
  logic        card_prev_reg;
  logic        protected_now;
  logic [47:0] key_flat;
  logic        cmd_wr;
  logic        key_good;
  logic        key_match;

  assign protected_now = prot_en_reg && !unlocked_reg;
  assign key_flat      = {key_reg[2], key_reg[1], key_reg[0]};
  assign cmd_wr        = wr && (addr == idr_pkg::CMD_IDX);

  // Block order and sizes are constants, so software always finds each block.
  function automatic idr_pkg::idr_blk_t blk_of(input logic [13:0] idx);
    if (idx < idr_pkg::F2P_BASE) return idr_pkg::BLK_OUT;            // [RL1] [RL3]
    else if (idx < idr_pkg::RSV_BASE) return idr_pkg::BLK_F2P;       // [RL4]
    else if (idx < idr_pkg::REQ_BASE) return idr_pkg::BLK_RSV;       // [RL4] [RL5]
    else if (idx < idr_pkg::R114_BASE) return idr_pkg::BLK_REQ;      // [RL6]
    else if (idx < idr_pkg::RESP_BASE) return idr_pkg::BLK_RSV;      // [RL5]
    else if (idx < idr_pkg::RO_BASE) return idr_pkg::BLK_RESP;       // [RL6]
    else if (idx < idr_pkg::STAT_BASE) return idr_pkg::BLK_RO;       // [RL5]
    else if (idx < idr_pkg::INP_BASE) return idr_pkg::BLK_STAT;      // [RL7]
    else if (idx < idr_pkg::P2F_BASE) return idr_pkg::BLK_INP;       // [RL8]
    else if (idx < idr_pkg::IMG_END) return idr_pkg::BLK_P2F;        // [RL10]
    else if (idx >= idr_pkg::CTRL_IDX && idx <= idr_pkg::STATUS_IDX)
      return idr_pkg::BLK_CTRL;
    else return idr_pkg::BLK_NONE;
  endfunction

  // Every image word reads back for any port; reserved space reads as zero.
  function automatic logic [15:0] rd_word(input logic [13:0] idx);
    logic [13:0] off;
    logic [15:0] w;
    off = 14'h0000;
    w   = idr_pkg::RST_WORD;
    case (blk_of(idx))
      idr_pkg::BLK_OUT: w = out_img[idx[11:0]];
      idr_pkg::BLK_F2P: begin
        off = idx - idr_pkg::F2P_BASE;
        w   = f2p_tab[off[8:0]];
      end
      idr_pkg::BLK_REQ: begin
        off = idx - idr_pkg::REQ_BASE;
        w   = req_blk[off[2:0]];
      end
      idr_pkg::BLK_RESP: begin
        off = idx - idr_pkg::RESP_BASE;
        w   = resp_blk[off[1:0]];
      end
      idr_pkg::BLK_STAT: begin
        off = idx - idr_pkg::STAT_BASE;
        w   = stat_blk[off[5:0]];
      end
      idr_pkg::BLK_INP: begin
        off = idx - idr_pkg::INP_BASE;
        w   = inp_img[off[11:0]];
      end
      idr_pkg::BLK_P2F: begin
        off = idx - idr_pkg::P2F_BASE;
        w   = p2f_tab[off[8:0]];
      end
      idr_pkg::BLK_CTRL: begin
        off = idx - idr_pkg::KEY0_IDX;
        // The command register reads zero; commands are strobes, not state.
        if (idx == idr_pkg::CTRL_IDX) begin
          w[idr_pkg::CTRL_TEST_BIT] = test_mode;
          w[idr_pkg::CTRL_PROT_BIT] = prot_en_reg;
        end else if (idx == idr_pkg::KEYLEN_IDX)
          w = {12'h000, key_len_reg};
        else if (idx == idr_pkg::STATUS_IDX) begin
          w[idr_pkg::STS_PROT_BIT]    = protected_now;
          w[idr_pkg::STS_OPEN_BIT]    = unlocked_reg;
          w[idr_pkg::STS_REFUSED_BIT] = refused_reg;
        end else if (idx < idr_pkg::KEYLEN_IDX)
          w = key_reg[off[1:0]];
      end
      default: w = idr_pkg::RST_WORD;
    endcase
    return w;
  endfunction

  // Length at most six and every counted byte a letter or a digit.
  function automatic logic pw_ok(input logic [47:0] k, input logic [3:0] len);
    logic       ok;
    logic [7:0] c;
    ok = (len <= idr_pkg::PW_MAXLEN);
    for (int i = 0; i < idr_pkg::PW_CHARS; i++) begin
      c = k[8*i +: 8];
      if (4'(i) < len && !((c >= 8'h30 && c <= 8'h39) ||
                           (c >= 8'h41 && c <= 8'h5a) ||
                           (c >= 8'h61 && c <= 8'h7a)))
        ok = 1'b0;
    end
    return ok;
  endfunction

  // Bytes past the length are cleared so stale key bytes never decide a match.
  function automatic logic [47:0] pw_mask(input logic [47:0] k, input logic [3:0] len);
    logic [47:0] m;
    m = 48'h000000000000;
    for (int i = 0; i < idr_pkg::PW_CHARS; i++) begin
      if (4'(i) < len)
        m[8*i +: 8] = k[8*i +: 8];
    end
    return m;
  endfunction

  // A key of another length never matches, even when its bytes agree.
  assign key_good  = pw_ok(key_flat, key_len_reg);                   // [RL20]
  assign key_match = key_good && (key_len_reg == pw_len_reg) &&
                     (pw_mask(key_flat, key_len_reg) == pw_reg);     // [RL20]

  // Read data stand for exactly the cycle after the strobe and are zero
  // otherwise, so a late sampler sees zero rather than stale data.
  always_ff @(posedge clk or posedge rst) begin
    if (rst)
      rdata <= idr_pkg::RST_WORD;
    else
      rdata <= rd ? rd_word(addr) : idr_pkg::RST_WORD;               // [RL11] [RL17]
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst)
      fb_rdata <= idr_pkg::RST_WORD;
    else
      fb_rdata <= fb_rd ? rd_word(fb_addr) : idr_pkg::RST_WORD;      // [RL11]
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst)
      isl_rdata <= idr_pkg::RST_WORD;
    else
      isl_rdata <= isl_rd ? rd_word(isl_addr) : idr_pkg::RST_WORD;   // [RL11]
  end

  // Fieldbus owns the output image; in test mode the panel is island master
  // and fieldbus writes are dropped so the two never race for a word.
  // Words are kept whole, so channel bit layout and analog justification
  // written by the master reach the modules unchanged.
  always_ff @(posedge clk) begin
    if (fb_wr && blk_of(fb_addr) == idr_pkg::BLK_OUT && !test_mode)
      out_img[fb_addr[11:0]] <= fb_wdata;                            // [RL13] [RL14] [RL15] [RL16]
    else if (wr && blk_of(addr) == idr_pkg::BLK_OUT && test_mode)
      out_img[addr[11:0]] <= wdata;                                  // [RL12]
  end

  always_ff @(posedge clk) begin
    logic [13:0] off;
    off = fb_addr - idr_pkg::F2P_BASE;
    if (fb_wr && blk_of(fb_addr) == idr_pkg::BLK_F2P)
      f2p_tab[off[8:0]] <= fb_wdata;                                 // [RL4]
  end

  always_ff @(posedge clk) begin
    logic [13:0] off;
    off = addr - idr_pkg::REQ_BASE;
    if (wr && blk_of(addr) == idr_pkg::BLK_REQ)
      req_blk[off[2:0]] <= wdata;                                    // [RL6]
  end

  always_ff @(posedge clk) begin
    logic [13:0] off;
    off = addr - idr_pkg::P2F_BASE;
    if (wr && blk_of(addr) == idr_pkg::BLK_P2F && off < idr_pkg::P2F_WR_COUNT)
      p2f_tab[off[8:0]] <= wdata;                                    // [RL9]
  end

  // Island side fills status, response and input blocks; reserved and
  // read-only space has no storage, so writes there are lost.
  always_ff @(posedge clk) begin
    logic [13:0] off;
    off = 14'h0000;
    case (blk_of(isl_addr))
      idr_pkg::BLK_RESP: begin
        off = isl_addr - idr_pkg::RESP_BASE;
        if (isl_wr) resp_blk[off[1:0]] <= isl_wdata;                 // [RL6]
      end
      idr_pkg::BLK_STAT: begin
        off = isl_addr - idr_pkg::STAT_BASE;
        if (isl_wr) stat_blk[off[5:0]] <= isl_wdata;                 // [RL7]
      end
      idr_pkg::BLK_INP: begin
        off = isl_addr - idr_pkg::INP_BASE;
        if (isl_wr) inp_img[off[11:0]] <= isl_wdata;                 // [RL8]
      end
      default: off = 14'h0000;                                       // [RL23]
    endcase
  end

  // Key entry registers.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      key_reg[0]  <= idr_pkg::RST_WORD;
      key_reg[1]  <= idr_pkg::RST_WORD;
      key_reg[2]  <= idr_pkg::RST_WORD;
      key_len_reg <= 4'h0;
    end else if (wr && blk_of(addr) == idr_pkg::BLK_CTRL) begin
      if (addr >= idr_pkg::KEY0_IDX && addr < idr_pkg::KEYLEN_IDX)
        key_reg[2'(addr - idr_pkg::KEY0_IDX)] <= wdata;
      else if (addr == idr_pkg::KEYLEN_IDX)
        key_len_reg <= wdata[3:0];
    end
  end

  // Test mode may always change; the protection enable only while open.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      test_mode   <= 1'b0;
      prot_en_reg <= 1'b0;
    end else if (wr && addr == idr_pkg::CTRL_IDX) begin
      test_mode <= wdata[idr_pkg::CTRL_TEST_BIT];
      if (!protected_now)
        prot_en_reg <= wdata[idr_pkg::CTRL_PROT_BIT];                // [RL17]
    end
  end

  // Password state and unlock commands.
  // Lock is never refused, so an open island can always be closed again.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      unlocked_reg <= 1'b0;
      pw_reg       <= 48'h000000000000;
      pw_len_reg   <= 4'h0;
    end else if (cmd_wr) begin
      case (wdata)
        idr_pkg::CMD_UNLOCK: if (key_match) unlocked_reg <= 1'b1;    // [RL20]
        idr_pkg::CMD_LOCK: unlocked_reg <= 1'b0;
        idr_pkg::CMD_SET_PW: begin
          if (!protected_now && key_good) begin                      // [RL17] [RL20]
            pw_reg     <= pw_mask(key_flat, key_len_reg);
            pw_len_reg <= key_len_reg;
          end
        end
        default: unlocked_reg <= unlocked_reg;
      endcase
    end
  end

  // Last command outcome, shown in the status register.
  always_ff @(posedge clk or posedge rst) begin
    if (rst)
      refused_reg <= 1'b0;
    else if (cmd_wr) begin
      case (wdata)
        idr_pkg::CMD_UNLOCK: refused_reg <= !key_match;
        idr_pkg::CMD_SET_PW: refused_reg <= protected_now || !key_good;
        idr_pkg::CMD_SAVE,
        idr_pkg::CMD_CARD: refused_reg <= protected_now;             // [RL17]
        default: refused_reg <= 1'b0;
      endcase
    end
  end

  // Commit pulses last one cycle; a refused command leaves both low.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cfg_save   <= 1'b0;
      card_store <= 1'b0;
    end else begin
      cfg_save   <= cmd_wr && wdata == idr_pkg::CMD_SAVE && !protected_now;  // [RL22]
      card_store <= cmd_wr && wdata == idr_pkg::CMD_CARD && !protected_now;  // [RL22]
    end
  end

  // The password travels with every save so that flash or card never holds
  // a configuration without its protection.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      saved_pw     <= 48'h000000000000;
      saved_pw_len <= 4'h0;
      saved_pw_en  <= 1'b0;
    end else if (cmd_wr && !protected_now &&
                 (wdata == idr_pkg::CMD_SAVE || wdata == idr_pkg::CMD_CARD)) begin
      saved_pw     <= prot_en_reg ? pw_reg : 48'h000000000000;       // [RL21]
      saved_pw_len <= prot_en_reg ? pw_len_reg : 4'h0;
      saved_pw_en  <= prot_en_reg;
    end
  end

  // Button and card act on their rising edge only, so a card left in while
  // protected is not loaded later when the island is unlocked.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      button_prev_reg <= 1'b0;
      cfg_reset       <= 1'b0;
    end else begin
      button_prev_reg <= reset_button;
      cfg_reset       <= reset_button && !button_prev_reg && !protected_now;  // [RL18]
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      card_prev_reg <= 1'b0;
      card_load     <= 1'b0;
    end else begin
      card_prev_reg <= card_present;
      card_load     <= card_present && !card_prev_reg && !protected_now;      // [RL19]
    end
  end

endmodule

// ### bench/idr_far_side.sv
// Fieldbus master and island side model that drive the two far ports.
// Assumes the bench calls its one task in turn, never two at once.
module idr_far_side (
  // Clock
  input  wire logic        clk,
  // Fieldbus master port
  output logic      [13:0] fb_addr,
  output logic      [15:0] fb_wdata,
  output logic             fb_wr,
  output logic             fb_rd,
  input  wire logic [15:0] fb_rdata,
  // Island side port
  output logic      [13:0] isl_addr,
  output logic      [15:0] isl_wdata,
  output logic             isl_wr,
  output logic             isl_rd,
  input  wire logic [15:0] isl_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    {fb_addr, fb_wdata, fb_wr, fb_rd} = 32'h0000_0000;
    {isl_addr, isl_wdata, isl_wr, isl_rd} = 32'h0000_0000;
  end
  // The fieldbus writes output data; the island fills inputs and status.
  task automatic acc(input bit isl, input bit w, input logic [13:0] a,
                     input logic [15:0] d, output logic [15:0] q);
    @(posedge clk);
    if (isl) begin
      {isl_addr, isl_wdata, isl_wr, isl_rd} <= {a, d, w, !w};
    end else begin
      {fb_addr, fb_wdata, fb_wr, fb_rd} <= {a, d, w, !w};
    end
    @(posedge clk);
    // Released lines show the inverse so a stale value can never pass.
    {fb_addr, fb_wdata, fb_wr, fb_rd} <= {~fb_addr, ~fb_wdata, 2'b00};
    {isl_addr, isl_wdata, isl_wr, isl_rd} <= {~isl_addr, ~isl_wdata, 2'b00};
    @(negedge clk);
    q = isl ? isl_rdata : fb_rdata;
  endtask
endmodule

// ### bench/idr_regs_checker.sv
// Concurrent checks on the register bank ports.
// Assumes one clock and the active high asynchronous reset.
module idr_regs_checker (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic [13:0] addr,
  input wire logic [15:0] wdata,
  input wire logic        wr,
  input wire logic        rd,
  input wire logic [15:0] rdata,
  input wire logic        fb_rd,
  input wire logic [15:0] fb_rdata,
  input wire logic        isl_rd,
  input wire logic [15:0] isl_rdata,
  input wire logic        reset_button,
  input wire logic        card_present,
  input wire logic        cfg_save,
  input wire logic        card_store,
  input wire logic        card_load,
  input wire logic        cfg_reset,
  input wire logic        test_mode,
  input wire logic [3:0]  saved_pw_len
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  a_cfg_rdata_idle: assert property (!$past(rd) |-> rdata == 16'h0000)
    else $error("config read data not idle");
  a_fb_rdata_idle: assert property (!$past(fb_rd) |-> fb_rdata == 16'h0000)
    else $error("fieldbus read data not idle");
  a_isl_rdata_idle: assert property (!$past(isl_rd) |-> isl_rdata == 16'h0000)
    else $error("island read data not idle");
  a_unmapped_read_zero: assert property ($past(rd) && $past(addr) > idr_pkg::STATUS_IDX
    |-> rdata == 16'h0000) else $error("unmapped read not zero");
  a_save_cause: assert property (cfg_save |-> $past(wr) && $past(addr) == idr_pkg::CMD_IDX
    && $past(wdata) == idr_pkg::CMD_SAVE) else $error("save pulse without command");
  a_card_store_cause: assert property (card_store |-> $past(wr)
    && $past(addr) == idr_pkg::CMD_IDX && $past(wdata) == idr_pkg::CMD_CARD)
    else $error("card store pulse without command");
  a_button_edge: assert property (cfg_reset |-> $past(reset_button)
    && !$past(reset_button, 2)) else $error("reset pulse without button edge");
  a_card_edge: assert property (card_load |-> $past(card_present)
    && !$past(card_present, 2)) else $error("card load without insertion");
  a_test_mode_cause: assert property ($changed(test_mode) |-> $past(wr)
    && $past(addr) == idr_pkg::CTRL_IDX) else $error("test mode moved alone");
  a_pw_with_save: assert property ($changed(saved_pw_len) |-> cfg_save || card_store)
    else $error("stored password moved without save");
  c_save: cover property (cfg_save);
  c_card_store: cover property (card_store);
  c_button: cover property (cfg_reset);
endmodule

bind idr_regs idr_regs_checker u_chk (.clk, .rst, .addr, .wdata, .wr, .rd, .rdata, .fb_rd,
  .fb_rdata, .isl_rd, .isl_rdata, .reset_button, .card_present, .cfg_save, .card_store,
  .card_load, .cfg_reset, .test_mode, .saved_pw_len);

// ### bench/idr_regs_tb.sv
// Self-checking bench for the island data image register bank.
// Assumes the package is compiled first and the checker is bound to the design.
module idr_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [13:0] addr = 14'h0000;
  logic [15:0] wdata = 16'h0000;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic        reset_button = 1'b0;
  logic        card_present = 1'b0;
  logic [15:0] rdata, fb_rdata, isl_rdata, fb_wdata, isl_wdata, q;
  logic [13:0] fb_addr, isl_addr;
  logic        fb_wr, fb_rd, isl_wr, isl_rd;
  logic        cfg_save, card_store, card_load, cfg_reset, test_mode, saved_pw_en;
  logic [47:0] saved_pw;
  logic [3:0]  saved_pw_len;
  logic [3:0]  seen = 4'h0;
  logic        seen_clr = 1'b0;
  logic [13:0] isl_idx [5] = '{14'h150f, 14'h250e, 14'h14ec, 14'h150e, 14'h14b6};
  int          errors = 0;
  int          checks_done = 0;

  always #10 clk = ~clk;
  // Sticky record of the action pulses, so a check need not hit the exact cycle.
  always @(posedge clk)
    seen <= (seen_clr ? 4'h0 : seen) | {cfg_save, card_store, card_load, cfg_reset};

  idr_regs u_dut (.clk, .rst, .addr, .wdata, .wr, .rd, .rdata, .fb_addr, .fb_wdata, .fb_wr,
    .fb_rd, .fb_rdata, .isl_addr, .isl_wdata, .isl_wr, .isl_rd, .isl_rdata, .reset_button,
    .card_present, .cfg_save, .card_store, .card_load, .cfg_reset, .test_mode, .saved_pw,
    .saved_pw_len, .saved_pw_en);
  idr_far_side u_far (.clk, .fb_addr, .fb_wdata, .fb_wr, .fb_rd, .fb_rdata, .isl_addr,
    .isl_wdata, .isl_wr, .isl_rd, .isl_rdata);

  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic print_verdict();
    $display("checks=%0d errors=%0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic cw(input logic [13:0] a, input logic [15:0] d);
    @(posedge clk);
    {addr, wdata, wr} <= {a, d, 1'b1};
    @(posedge clk);
    {addr, wdata, wr} <= {~a, ~d, 1'b0};
  endtask
  task automatic rchk(input logic [13:0] a, input logic [15:0] e);
    @(posedge clk);
    {addr, rd} <= {a, 1'b1};
    @(posedge clk);
    {addr, rd} <= {~a, 1'b0};
    @(negedge clk);
    check(rdata, e);
  endtask
  task automatic pulse_chk(input logic [3:0] e);
    repeat (3) @(posedge clk);
    @(negedge clk);
    check(seen, e);
    seen_clr <= 1'b1;
    @(posedge clk);
    seen_clr <= 1'b0;
  endtask
  task automatic press(input logic [1:0] v, input logic [3:0] e);
    @(posedge clk);
    {card_present, reset_button} <= v;
    pulse_chk(e);
    @(posedge clk);
    {card_present, reset_button} <= 2'b00;
  endtask

  initial begin
    #100us;
    errors++;
    print_verdict();
  end

  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    check({cfg_save, card_store, card_load, cfg_reset, test_mode, saved_pw_en}, 0);
    u_far.acc(1'b0, 1'b1, 14'h0000, 16'h0001, q);
    u_far.acc(1'b0, 1'b1, 14'h0fff, 16'hfff0, q);
    u_far.acc(1'b0, 1'b1, 14'h1000, 16'h1234, q);
    cw(14'h0000, 16'hbeef);
    rchk(14'h0000, 16'h0001);
    rchk(14'h0fff, 16'hfff0);
    rchk(14'h1000, 16'h1234);
    $display("test fieldbus outputs done");
    cw(idr_pkg::CTRL_IDX, 16'h0001);
    @(negedge clk);
    check(test_mode, 1'b1);
    cw(14'h0000, 16'h00a5);
    u_far.acc(1'b0, 1'b1, 14'h0000, 16'h0002, q);
    rchk(14'h0000, 16'h00a5);
    cw(idr_pkg::CTRL_IDX, 16'h0000);
    $display("test test mode done");
    cw(14'h250f, 16'h5a5a);
    cw(14'h270e, 16'ha5a5);
    rchk(14'h250f, 16'h5a5a);
    u_far.acc(1'b0, 1'b0, 14'h270e, 16'h0000, q);
    check(q, 16'ha5a5);
    rchk(14'h3fff, 16'h0000);
    cw(14'h140d, 16'h1357);
    cw(14'h1200, 16'hffff);
    cw(14'h14ba, 16'hffff);
    rchk(14'h140d, 16'h1357);
    rchk(14'h1200, 16'h0000);
    rchk(14'h14ba, 16'h0000);
    for (int i = 0; i < 5; i++) begin
      u_far.acc(1'b1, 1'b1, isl_idx[i], 16'h1110 + 16'(i), q);
      cw(isl_idx[i], 16'hffff);
      rchk(isl_idx[i], 16'h1110 + 16'(i));
      u_far.acc(1'b1, 1'b0, isl_idx[i], 16'h0000, q);
      check(q, 16'h1110 + 16'(i));
    end
    $display("test block map done");
    pulse_chk(4'h0);
    cw(idr_pkg::KEY0_IDX, 16'h4261);
    cw(idr_pkg::KEY0_IDX + 14'h0001, 16'h0000);
    cw(idr_pkg::KEY0_IDX + 14'h0002, 16'h0000);
    cw(idr_pkg::KEYLEN_IDX, 16'h0002);
    cw(idr_pkg::CMD_IDX, idr_pkg::CMD_SET_PW);
    cw(idr_pkg::CTRL_IDX, 16'h0002);
    rchk(idr_pkg::STATUS_IDX, 16'h0001);
    cw(idr_pkg::CMD_IDX, idr_pkg::CMD_UNLOCK);
    rchk(idr_pkg::STATUS_IDX, 16'h0002);
    cw(idr_pkg::CMD_IDX, idr_pkg::CMD_SAVE);
    pulse_chk(4'b1000);
    check({saved_pw_en, saved_pw_len, saved_pw}, {1'b1, 4'h2, 48'h0000_0000_4261});
    cw(idr_pkg::CMD_IDX, idr_pkg::CMD_LOCK);
    cw(idr_pkg::CMD_IDX, idr_pkg::CMD_SAVE);
    pulse_chk(4'h0);
    rchk(14'h0000, 16'h00a5);
    press(2'b01, 4'h0);
    press(2'b10, 4'h0);
    cw(idr_pkg::KEY0_IDX, 16'h6241);
    cw(idr_pkg::CMD_IDX, idr_pkg::CMD_UNLOCK);
    rchk(idr_pkg::STATUS_IDX, 16'h0005);
    cw(idr_pkg::KEY0_IDX, 16'h4261);
    cw(idr_pkg::CMD_IDX, idr_pkg::CMD_UNLOCK);
    cw(idr_pkg::CMD_IDX, idr_pkg::CMD_CARD);
    pulse_chk(4'b0100);
    press(2'b01, 4'b0001);
    press(2'b10, 4'b0010);
    $display("test protection done");
    print_verdict();
  end
endmodule
